// File: core/tmr_regs.svh
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
// register byte addresses
`define TMR_ADDR_CTRL_A 12'h000
`define TMR_ADDR_CTRL_B 12'h004
`define TMR_ADDR_COUNT 12'h008
`define TMR_ADDR_CMP_A 12'h00c
`define TMR_ADDR_CMP_B 12'h010
`define TMR_ADDR_MASK 12'h014
`define TMR_ADDR_FLAGS 12'h018
`define TMR_ADDR_GIE 12'h01c
// control b fields
`define TMR_B_FORCE_A 7
`define TMR_B_FORCE_B 6
`define TMR_B_WAVE_HIGH 3
`define TMR_B_RW_MASK 8'h0f
// control a fields
`define TMR_A_RW_MASK 8'hf3
// mask and flag fields
`define TMR_IRQ_OVF 0
`define TMR_IRQ_CMPA 1
`define TMR_IRQ_CMPB 2
`define TMR_IRQ_RW_MASK 8'h07
// reset values
`define TMR_RST_BYTE 8'h00
// fixed counter values
`define TMR_MAX 8'hff
`define TMR_BOTTOM 8'h00
// prescaler taps
`define TMR_DIV_8 10'd7
`define TMR_DIV_64 10'd63
`define TMR_DIV_256 10'd255
`define TMR_DIV_1024 10'd1023
`endif

// File: core/tmr_pkg.sv
package tmr_pkg;
	typedef enum logic [2:0]
	{
		TMR_CS_STOP = 3'b000,
		TMR_CS_DIV1 = 3'b001,
		TMR_CS_DIV8 = 3'b010,
		TMR_CS_DIV64 = 3'b011,
		TMR_CS_DIV256 = 3'b100,
		TMR_CS_DIV1024 = 3'b101,
		TMR_CS_EXT_FALL = 3'b110,
		TMR_CS_EXT_RISE = 3'b111
	} tmr_clock_select_t;
	typedef struct packed
	{
		logic ovf;
		logic cmpa;
		logic cmpb;
	} tmr_irq_t;
	typedef struct packed
	{
		logic [1:0] out_mode_a;
		logic [1:0] out_mode_b;
		logic [2:0] wave_mode;
		logic [2:0] clock_select;
	} tmr_cfg_t;
endpackage

// File: core/tmr_timer8.sv
`timescale 1ns/1ps
`include "tmr_regs.svh"
// Overview of operation
// R01: force strobes ignored in PWM modes
// R02: software writes zero force bits in PWM
// R03: force strobe makes immediate match on output
// R04: forced match sets no flag, no clear
// R05: force bits always read zero
// R06: reserved bits read as zero
// R07: clock select: stop, prescale taps, pin edges
// R08: pin edges count even when pin output
// R09: counter register readable and writable
// R10: counter write blocks next timer-clock match
// R11: compare registers continuously compared to counter
// R12: compare b irq needs mask, global, flag
// R13: compare a irq needs mask, global, flag
// R14: overflow irq needs mask, global, flag
// R15: flag 2 sets on compare b match
// R16: flag 1 sets on compare a match
// R17: flags cleared when vector executes
// R18: write one clears flag, zero keeps
// R19: overflow flag point depends on mode
// R20: wave mode bits select sequence and top
// R21: overflow at max, bottom or top per mode
// R22: non-pwm output codes toggle, clear, set
// R23: acknowledge input clears matching flag
module tmr_timer8
	import tmr_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external count pin
	input wire logic ext_count_pin,
	// interrupt controller
	input wire tmr_irq_t irq_ack,
	output tmr_irq_t irq_req,
	// waveform
	output logic wave_out_a,
	output logic wave_out_b,
	output logic wave_en_a,
	output logic wave_en_b
);
	logic [7:0] ctrl_a_reg;
	logic [7:0] ctrl_b_reg;
	logic [7:0] count_reg;
	logic [7:0] cmp_a_reg;
	logic [7:0] cmp_b_reg;
	logic [7:0] mask_reg;
	logic [7:0] flags_reg;
	logic gie_reg;
	logic [9:0] presc_reg;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_s3_reg;
	logic dir_down_reg;
	logic block_reg;
	logic wave_a_reg;
	logic wave_b_reg;
	logic [7:0] ocr_a_buf_reg;
	logic [7:0] ocr_b_buf_reg;
	logic [7:0] count_next;
	logic [7:0] flags_next;
	logic dir_down_next;

	tmr_cfg_t cfg;
	wire wr = psel && penable && pwrite;
	wire rd_any = psel && !pwrite;
	wire hit_ctrl_a = paddr == `TMR_ADDR_CTRL_A;
	wire hit_ctrl_b = paddr == `TMR_ADDR_CTRL_B;
	wire hit_count = paddr == `TMR_ADDR_COUNT;
	wire hit_cmp_a = paddr == `TMR_ADDR_CMP_A;
	wire hit_cmp_b = paddr == `TMR_ADDR_CMP_B;
	wire hit_mask = paddr == `TMR_ADDR_MASK;
	wire hit_flags = paddr == `TMR_ADDR_FLAGS;
	wire hit_gie = paddr == `TMR_ADDR_GIE;
	wire hit_any = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a | hit_cmp_b | hit_mask
		| hit_flags | hit_gie;
	wire [7:0] wbyte = pwdata[7:0];

	assign cfg.out_mode_a = ctrl_a_reg[7:6];
	assign cfg.out_mode_b = ctrl_a_reg[5:4];
	assign cfg.wave_mode = {ctrl_b_reg[`TMR_B_WAVE_HIGH], ctrl_a_reg[1:0]}; // [R20]
	assign cfg.clock_select = ctrl_b_reg[2:0];

	// mode decode
	wire mode_pc = cfg.wave_mode[1:0] == 2'b01; // [R20]
	wire mode_fast = cfg.wave_mode[1:0] == 2'b11;
	wire mode_ctc = cfg.wave_mode == 3'b010;
	wire top_is_a = cfg.wave_mode[2];
	wire non_pwm = !cfg.wave_mode[0]; // normal, ctc (and reserved)
	wire [7:0] top_val = (mode_ctc || top_is_a) ? ocr_a_buf_reg : `TMR_MAX; // [R20]

	// clock select: prescaled tick or synchronised pin edge
	wire pin_rise = pin_s2_reg && !pin_s3_reg;
	wire pin_fall = !pin_s2_reg && pin_s3_reg;
	logic tick;
	always_comb
	begin
		case (cfg.clock_select) // [R07]
			TMR_CS_STOP: tick = 1'b0;
			TMR_CS_DIV1: tick = 1'b1;
			TMR_CS_DIV8: tick = (presc_reg & `TMR_DIV_8) == `TMR_DIV_8;
			TMR_CS_DIV64: tick = (presc_reg & `TMR_DIV_64) == `TMR_DIV_64;
			TMR_CS_DIV256: tick = (presc_reg & `TMR_DIV_256) == `TMR_DIV_256;
			TMR_CS_DIV1024: tick = presc_reg == `TMR_DIV_1024;
			TMR_CS_EXT_FALL: tick = pin_fall; // [R08]
			TMR_CS_EXT_RISE: tick = pin_rise; // [R08]
			default: tick = 1'b0;
		endcase
	end

	// compare and overflow events on a timer tick
	wire wr_count = wr && hit_count;
	wire match_a = tick && !block_reg && count_reg == ocr_a_buf_reg; // [R11] [R10]
	wire match_b = tick && !block_reg && count_reg == ocr_b_buf_reg; // [R11] [R10]
	wire at_top = count_reg == top_val;
	wire at_bottom = count_reg == `TMR_BOTTOM;
	logic ovf_evt;
	always_comb
	begin
		if (mode_pc)
			ovf_evt = tick && at_bottom && dir_down_reg; // [R21] [R19]
		else if (mode_fast && top_is_a)
			ovf_evt = tick && at_top; // [R21]
		else
			ovf_evt = tick && count_reg == `TMR_MAX; // [R21]
	end

	// counter sequence
	always_comb
	begin
		count_next = count_reg;
		dir_down_next = dir_down_reg;
		if (wr_count)
			count_next = wbyte; // [R09]
		else if (tick)
		begin
			if (mode_pc)
			begin
				if (at_top)
					dir_down_next = 1'b1;
				else if (at_bottom)
					dir_down_next = 1'b0;
				count_next = (dir_down_next) ? count_reg - 8'h01 : count_reg + 8'h01;
			end
			else if (at_top && top_val != `TMR_MAX)
				count_next = `TMR_BOTTOM;
			else
				count_next = count_reg + 8'h01;
		end
	end

	// force strobes only in non-pwm modes
	wire wr_ctrl_b = wr && hit_ctrl_b;
	wire force_a = wr_ctrl_b && wbyte[`TMR_B_FORCE_A] && non_pwm; // [R01] [R03]
	wire force_b = wr_ctrl_b && wbyte[`TMR_B_FORCE_B] && non_pwm; // [R01] [R03]

	function automatic logic wave_apply(input logic cur, input logic [1:0] om);
		case (om) // [R22]
			2'b01: wave_apply = !cur;
			2'b10: wave_apply = 1'b0;
			2'b11: wave_apply = 1'b1;
			default: wave_apply = cur;
		endcase
	endfunction

	function automatic logic pwm_wave(input logic cur, input logic [1:0] om, input logic m,
		input logic t, input logic dn);
		if (!om[1])
			pwm_wave = (om[0] && top_is_a && m) ? !cur : cur;
		else if (m)
			pwm_wave = om[0] ^ dn;
		else if (t && !mode_pc)
			pwm_wave = !om[0];
		else
			pwm_wave = cur;
	endfunction

	logic wave_a_next;
	logic wave_b_next;
	always_comb
	begin
		if (non_pwm)
		begin
			wave_a_next = (match_a || force_a) ? wave_apply(wave_a_reg, cfg.out_mode_a)
				: wave_a_reg; // [R03] [R22]
			wave_b_next = (match_b || force_b) ? wave_apply(wave_b_reg, cfg.out_mode_b)
				: wave_b_reg; // [R03]
		end
		else
		begin
			wave_a_next = pwm_wave(wave_a_reg, cfg.out_mode_a, match_a, tick && at_top,
				dir_down_reg);
			wave_b_next = pwm_wave(wave_b_reg, cfg.out_mode_b, match_b, tick && at_top,
				dir_down_reg);
		end
	end

	// flags: hardware set wins over clear; force does not set
	wire wr_flags = wr && hit_flags;
	tmr_irq_t set_evt;
	assign set_evt.ovf = ovf_evt;
	assign set_evt.cmpa = match_a; // [R04] [R16]
	assign set_evt.cmpb = match_b; // [R04] [R15]
	wire [2:0] set_vec = {set_evt.cmpb, set_evt.cmpa, set_evt.ovf};
	wire [2:0] ack_vec = {irq_ack.cmpb, irq_ack.cmpa, irq_ack.ovf};
	wire [2:0] w1c_vec = wr_flags ? wbyte[2:0] : 3'b000; // [R18]
	always_comb
	begin
		flags_next = 8'h00;
		flags_next[2:0] = set_vec | (flags_reg[2:0] & ~w1c_vec & ~ack_vec); // [R17] [R23]
	end

	// pwm modes update compare buffers at top, others immediately
	wire buf_load = !(mode_pc || mode_fast) || (tick && at_top);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_a_reg <= `TMR_RST_BYTE;
			ctrl_b_reg <= `TMR_RST_BYTE;
			count_reg <= `TMR_RST_BYTE;
			cmp_a_reg <= `TMR_RST_BYTE;
			cmp_b_reg <= `TMR_RST_BYTE;
			mask_reg <= `TMR_RST_BYTE;
			flags_reg <= `TMR_RST_BYTE;
			gie_reg <= 1'b0;
			ocr_a_buf_reg <= `TMR_RST_BYTE;
			ocr_b_buf_reg <= `TMR_RST_BYTE;
			dir_down_reg <= 1'b0;
			wave_a_reg <= 1'b0;
			wave_b_reg <= 1'b0;
		end
		else
		begin
			if (wr && hit_ctrl_a)
				ctrl_a_reg <= wbyte & `TMR_A_RW_MASK;
			if (wr_ctrl_b)
				ctrl_b_reg <= wbyte & `TMR_B_RW_MASK; // [R05] [R06]
			if (wr && hit_cmp_a)
				cmp_a_reg <= wbyte;
			if (wr && hit_cmp_b)
				cmp_b_reg <= wbyte;
			if (wr && hit_mask)
				mask_reg <= wbyte & `TMR_IRQ_RW_MASK; // [R06]
			if (wr && hit_gie)
				gie_reg <= wbyte[0];
			if (buf_load)
			begin
				ocr_a_buf_reg <= cmp_a_reg;
				ocr_b_buf_reg <= cmp_b_reg;
			end
			count_reg <= count_next;
			dir_down_reg <= dir_down_next;
			flags_reg <= flags_next;
			wave_a_reg <= wave_a_next;
			wave_b_reg <= wave_b_next;
		end
	end

	// prescaler, pin synchroniser, match block
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			presc_reg <= 10'd0;
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
			block_reg <= 1'b0;
		end
		else
		begin
			presc_reg <= presc_reg + 10'd1;
			pin_s1_reg <= ext_count_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			if (wr_count)
				block_reg <= 1'b1; // [R10]
			else if (tick)
				block_reg <= 1'b0;
		end
	end

	// read mux
	logic [7:0] rbyte;
	always_comb
	begin
		rbyte = 8'h00;
		if (hit_ctrl_a)
			rbyte = ctrl_a_reg;
		else if (hit_ctrl_b)
			rbyte = ctrl_b_reg; // [R05]
		else if (hit_count)
			rbyte = count_reg; // [R09]
		else if (hit_cmp_a)
			rbyte = cmp_a_reg;
		else if (hit_cmp_b)
			rbyte = cmp_b_reg;
		else if (hit_mask)
			rbyte = mask_reg; // [R06]
		else if (hit_flags)
			rbyte = flags_reg; // [R06]
		else if (hit_gie)
			rbyte = {7'h00, gie_reg};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_any && !penable)
			prdata <= {24'h000000, rbyte};
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	assign irq_req.ovf = gie_reg && mask_reg[`TMR_IRQ_OVF] && flags_reg[`TMR_IRQ_OVF]; // [R14]
	assign irq_req.cmpa = gie_reg && mask_reg[`TMR_IRQ_CMPA] && flags_reg[`TMR_IRQ_CMPA]; // [R13]
	assign irq_req.cmpb = gie_reg && mask_reg[`TMR_IRQ_CMPB] && flags_reg[`TMR_IRQ_CMPB]; // [R12]

	assign wave_out_a = wave_a_reg;
	assign wave_out_b = wave_b_reg;
	assign wave_en_a = cfg.out_mode_a != 2'b00;
	assign wave_en_b = cfg.out_mode_b != 2'b00;
endmodule

// File: test/tmr_timer8_checker.sv
`timescale 1ns/1ps
`include "tmr_regs.svh"
module tmr_timer8_checker
	import tmr_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// irq and wave
	input wire tmr_irq_t irq_req,
	input wire logic wave_en_a,
	input wire logic wave_en_b
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire bad = paddr > `TMR_ADDR_GIE || paddr[1:0] != 2'h0;
	sequence wr(logic [11:0] a);
		acc && pwrite && paddr == a;
	endsequence
	sequence rd(logic [11:0] a);
		acc && !pwrite && paddr == a;
	endsequence
	ready_high_a: assert property (acc |-> pready) else $error("ready low");
	unmapped_err_a: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access");
	mapped_ok_a: assert property (acc && !bad |-> !pslverr) else $error("bad error");
	ctrl_b_zero_a: assert property (rd(`TMR_ADDR_CTRL_B) |-> prdata[31:4] == 28'h0)
		else $error("control b read");
	irq_regs_zero_a: assert property (
		rd(`TMR_ADDR_MASK) or rd(`TMR_ADDR_FLAGS) |-> prdata[31:3] == 29'h0)
		else $error("irq reg read");
	gie_off_a: assert property (
		wr(`TMR_ADDR_GIE) ##0 !pwdata[0] |=> (irq_req == 3'h0) [*2])
		else $error("irq without gie");
	mask_off_a: assert property (
		wr(`TMR_ADDR_MASK) ##0 pwdata[2:0] == 3'h0 |=> (irq_req == 3'h0) [*2])
		else $error("irq without mask");
	en_a_set_a: assert property (
		wr(`TMR_ADDR_CTRL_A) ##0 pwdata[7:6] != 2'h0 |=> wave_en_a)
		else $error("output a off");
	en_b_clear_a: assert property (
		wr(`TMR_ADDR_CTRL_A) ##0 pwdata[5:4] == 2'h0 |=> !wave_en_b)
		else $error("output b on");
endmodule

// File: test/tmr_irq_ctrl_model.sv
`timescale 1ns/1ps
module tmr_irq_ctrl_model
	import tmr_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// interrupt lines
	input wire tmr_irq_t irq_req,
	output tmr_irq_t irq_ack,
	output int ack_count
);
	int hold;
	// one vector at a time, lowest bit first; pauses 2 or 5 cycles after each
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_ack <= 3'h0;
			ack_count <= 0;
			hold <= 0;
		end
		else if (irq_ack != 3'h0 || hold > 0)
		begin
			irq_ack <= 3'h0;
			hold <= hold > 0 ? hold - 1 : (ack_count[0] ? 1 : 4);
		end
		else if (irq_req != 3'h0)
		begin
			irq_ack <= irq_req & (~irq_req + 3'h1);
			ack_count <= ack_count + 1;
		end
	end
endmodule

// File: test/timer8_control_and_irq_test.sv
`timescale 1ns/1ps
`include "tmr_regs.svh"
module timer8_control_and_irq_test
	import tmr_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, ext_count_pin, e, x;
	logic pready, pslverr, wave_out_a, wave_out_b, wave_en_a, wave_en_b;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [31:0] seed = 32'h3d36;
	logic [7:0] d;
	tmr_irq_t irq_ack, irq_req;
	int fails, cmp_count, cyc, ack_count, n, t0, k;
	int dv [6] = '{1, 1, 8, 64, 256, 1024};
	logic [1:0] ms [4] = '{2'h2, 2'h3, 2'h1, 2'h1};
	logic [7:0] rm [6] = '{8'hf3, 8'hff, 8'hff, 8'hff, 8'h07, 8'h08};
	logic [11:0] ra [6] = '{`TMR_ADDR_CTRL_A, `TMR_ADDR_COUNT, `TMR_ADDR_CMP_A,
		`TMR_ADDR_CMP_B, `TMR_ADDR_MASK, `TMR_ADDR_CTRL_B};
	tmr_timer8 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_count_pin(ext_count_pin), .irq_ack(irq_ack),
		.irq_req(irq_req), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.wave_en_a(wave_en_a), .wave_en_b(wave_en_b));
	tmr_irq_ctrl_model cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
		.irq_ack(irq_ack), .ack_count(ack_count));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// apb transfer, entered just after a rising edge, leaves one idle edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] dd);
		apb(1'b1, a, {24'h0, dd});
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	initial
	begin
		{psel, penable, pwrite, ext_count_pin, presetn} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 8; k++)
		begin
			rd(12'(k * 4));
			chk(r, 32'h0);
		end
		for (k = 0; k < 24; k++)
		begin
			seed = xs(seed);
			d = seed[7:0] & (k % 6 == 5 ? 8'h38 : 8'hff);
			wr(ra[k % 6], d);
			rd(ra[k % 6]);
			chk(r, {24'h0, d & rm[k % 6]});
		end
		apb(1'b1, 12'h020, 32'h5a);
		rd(12'h020);
		chk({r[30:0], e}, 32'h1);
		// forced matches in clear-on-match mode, counter stopped
		wr(`TMR_ADDR_COUNT, 8'h33);
		wr(`TMR_ADDR_CMP_A, 8'h44);
		wr(`TMR_ADDR_FLAGS, 8'h07);
		x = 1'b0;
		for (k = 0; k < 4; k++)
		begin
			wr(`TMR_ADDR_CTRL_A, {ms[k], ms[k], 4'h2});
			wr(`TMR_ADDR_CTRL_B, 8'hc0);
			repeat (2) @(posedge pclk);
			x = ms[k] == 2'h1 ? !x : ms[k] == 2'h3;
			chk({wave_out_a, wave_out_b, wave_en_a, wave_en_b}, {x, x, 2'h3});
		end
		rd(`TMR_ADDR_COUNT);
		chk(r, 32'h33);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h0);
		wr(`TMR_ADDR_CTRL_A, 8'ha3);
		wr(`TMR_ADDR_CTRL_B, 8'h00);
		repeat (2) @(posedge pclk);
		chk({wave_out_a, wave_out_b}, 2'h3);
		wr(`TMR_ADDR_CTRL_A, 8'h00);
		for (k = 1; k < 6; k++)
		begin
			wr(`TMR_ADDR_COUNT, 8'h00);
			wr(`TMR_ADDR_CTRL_B, 8'(k));
			t0 = cyc;
			repeat (4 * dv[k]) @(posedge pclk);
			wr(`TMR_ADDR_CTRL_B, 8'h00);
			n = (cyc - t0) / dv[k];
			rd(`TMR_ADDR_COUNT);
			chk(r + 1 >= n && r <= n + 1, 32'h1);
		end
		for (k = 6; k < 8; k++)
		begin
			wr(`TMR_ADDR_COUNT, 8'h00);
			wr(`TMR_ADDR_CTRL_B, 8'(k));
			seed = xs(seed);
			n = 2 + seed[1:0];
			repeat (n)
			begin
				ext_count_pin <= 1'b1;
				repeat (4 + seed[4:2]) @(posedge pclk);
				ext_count_pin <= 1'b0;
				repeat (4 + seed[7:5]) @(posedge pclk);
			end
			wr(`TMR_ADDR_CTRL_B, 8'h00);
			rd(`TMR_ADDR_COUNT);
			chk(r, n);
		end
		wr(`TMR_ADDR_CMP_A, 8'h80);
		wr(`TMR_ADDR_CMP_B, 8'h90);
		wr(`TMR_ADDR_FLAGS, 8'h07);
		wr(`TMR_ADDR_CTRL_B, 8'h01);
		wr(`TMR_ADDR_COUNT, 8'h80);
		wr(`TMR_ADDR_CTRL_B, 8'h00);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h0);
		// run across both compares and the wrap
		wr(`TMR_ADDR_CMP_A, 8'hfd);
		wr(`TMR_ADDR_CMP_B, 8'hfe);
		wr(`TMR_ADDR_COUNT, 8'hf8);
		wr(`TMR_ADDR_FLAGS, 8'h07);
		wr(`TMR_ADDR_CTRL_B, 8'h01);
		repeat (6) @(posedge pclk);
		wr(`TMR_ADDR_CTRL_B, 8'h00);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h7);
		wr(`TMR_ADDR_FLAGS, 8'h02);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h5);
		wr(`TMR_ADDR_MASK, 8'h04);
		repeat (8) @(posedge pclk);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h5);
		wr(`TMR_ADDR_GIE, 8'h01);
		repeat (8) @(posedge pclk);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h1);
		wr(`TMR_ADDR_MASK, 8'h03);
		repeat (8) @(posedge pclk);
		rd(`TMR_ADDR_FLAGS);
		chk(r, 32'h0);
		chk(ack_count, 32'h2);
		tally_and_finish;
	end
endmodule
bind tmr_timer8 tmr_timer8_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_req(irq_req), .wave_en_a(wave_en_a),
	.wave_en_b(wave_en_b));
